// file: logic/prio_bank_defines.svh
`ifndef PRIO_BANK_DEFINES_SVH
`define PRIO_BANK_DEFINES_SVH

// byte offsets of the five level registers and the gate register
`define OFF_PRIO_CTRL_1  12'h000
`define OFF_PRIO_CTRL_2  12'h004
`define OFF_PRIO_CTRL_3  12'h008
`define OFF_PRIO_CTRL_4  12'h00c
`define OFF_PRIO_CTRL_5  12'h010
`define OFF_SRC_ENABLE   12'h014
`define OFF_ADDR_W       12

// field layout: four 3-bit fields per register at these low bits
`define FLD_HI_LSB       12
`define FLD_MH_LSB       8
`define FLD_ML_LSB       4
`define FLD_LO_LSB       0
`define LEVEL_W          3
`define NUM_SRC          18
`define NUM_REGS         5

// level codes
`define LEVEL_OFF        3'h0
`define LEVEL_MIN        3'h1
`define LEVEL_MAX        3'h7
`define LEVEL_RESET      3'h4

// implemented-bit masks (unimplemented bits read zero)
`define MASK_FULL        16'h7777
`define MASK_REG3        16'h0777
`define MASK_REG4        16'h7077

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: logic/prio_bank_pkg.sv
package prio_bank_pkg;

  // one AXI4-Lite request carrier, used for writes only
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } bus_req_t;

  // per-source level outputs toward the arbiter
  typedef logic [2:0] level_t;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RESP = 2'b01
  } ch_state_t;

endpackage

// file: logic/level_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_defines.svh"

// one 16-bit level register with an implemented-bit mask
module level_reg #(
  parameter logic [15:0] MASK = `MASK_FULL
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_strb,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] value
);
  import prio_bank_pkg::*;

  logic [15:0] value_q;
  localparam logic [15:0] RST_ALL =
    {4{1'b0, `LEVEL_RESET}};

  // reset loads level four in each field; masked bits stay zero
  always_ff @(posedge aclk) begin // see RL4
    if (!aresetn) begin
      value_q <= RST_ALL & MASK;
    end else if (wr_en) begin // see RL6
      if (wr_strb[0]) begin
        value_q[7:0] <= wr_data[7:0] & MASK[7:0]; // see RL5
      end
      if (wr_strb[1]) begin
        value_q[15:8] <= wr_data[15:8] & MASK[15:8];
      end
    end
  end

  assign value = value_q;

  // unimplemented positions never hold a one
  AST_MASKED_ZERO: assert property ( // see RL5
    @(posedge aclk) disable iff (!aresetn)
    (value_q & ~MASK) == 16'h0000)
    else $error("unimplemented bit set");
endmodule
`default_nettype wire

// file: logic/src_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_defines.svh"

// gates each source's pending bit by its enable and a nonzero level code
module src_gate (
  input  wire logic [`NUM_SRC*`LEVEL_W-1:0] levels,
  input  wire logic [`NUM_SRC-1:0]          enables,
  input  wire logic [`NUM_SRC-1:0]          pending,
  output logic      [`NUM_SRC-1:0]          request
);
  import prio_bank_pkg::*;

  // code zero disables; a cleared enable blocks whatever the level
  always_comb begin
    for (int i = 0; i < `NUM_SRC; i++) begin
      request[i] = pending[i] && enables[i] && // see RL12
        (levels[i*`LEVEL_W +: `LEVEL_W] != `LEVEL_OFF); // see RL2
    end
  end
endmodule
`default_nettype wire

// file: logic/irq_priority_bank.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_defines.svh"

// Contract
// RL1: each level field is three bits; 111 is level 7, the highest.
// RL2: code 000 disables the source; it never raises a request.
// RL3: code 001 is level 1, lowest enabled; codes map linearly to 2-6.
// RL4: at reset every implemented field loads 100, level four.
// RL5: unimplemented bits always read back as zero.
// RL6: implemented bits are read/write; reads return last write or default.
// RL7: register 1 holds timer 2, compare 2, capture 2, dma 0 levels.
// RL8: register 2 holds uart 1 rx, spi 1 event, spi 1 error, timer 3.
// RL9: register 3 bits 15-11 unused; dma 1, adc 1, uart 1 tx.
// RL10: register 4 holds change notify, bits 11-7 unused, i2c master/slave.
// RL11: register 5 holds capture 8, capture 7, adc 2, external irq 1.
// RL12: a cleared enable bit blocks the request whatever the level.
// RL13: levels drive the arbiter continuously; writes act next cycle.
module irq_priority_bank (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [17:0]          src_pending,
  output prio_bank_pkg::level_t     timer_2_level,
  output prio_bank_pkg::level_t     out_compare_2_level,
  output prio_bank_pkg::level_t     in_capture_2_level,
  output prio_bank_pkg::level_t     dma_ch0_done_level,
  output prio_bank_pkg::level_t     uart_1_receive_level,
  output prio_bank_pkg::level_t     spi_1_event_level,
  output prio_bank_pkg::level_t     spi_1_error_level,
  output prio_bank_pkg::level_t     timer_3_level,
  output prio_bank_pkg::level_t     dma_ch1_done_level,
  output prio_bank_pkg::level_t     adc_1_done_level,
  output prio_bank_pkg::level_t     uart_1_transmit_level,
  output prio_bank_pkg::level_t     change_notify_level,
  output prio_bank_pkg::level_t     i2c_1_master_level,
  output prio_bank_pkg::level_t     i2c_1_slave_level,
  output prio_bank_pkg::level_t     in_capture_8_level,
  output prio_bank_pkg::level_t     in_capture_7_level,
  output prio_bank_pkg::level_t     adc_2_done_level,
  output prio_bank_pkg::level_t     ext_irq_1_level,
  output logic [17:0]               src_request
);
  import prio_bank_pkg::*;

  // field extraction shared by every level output assignment
  function automatic level_t fld(input logic [15:0] r, input int lsb);
    fld = r[lsb +: `LEVEL_W];
  endfunction

  // map an offset to a register select, index NUM_REGS means gate reg
  function automatic logic [3:0] decode(input logic [11:0] a);
    case (a)
      `OFF_PRIO_CTRL_1: decode = 4'h0;
      `OFF_PRIO_CTRL_2: decode = 4'h1;
      `OFF_PRIO_CTRL_3: decode = 4'h2;
      `OFF_PRIO_CTRL_4: decode = 4'h3;
      `OFF_PRIO_CTRL_5: decode = 4'h4;
      `OFF_SRC_ENABLE:  decode = 4'h5;
      default:          decode = 4'hf;
    endcase
  endfunction

  bus_req_t    wreq_q;
  logic        aw_have_q;
  logic        w_have_q;
  ch_state_t   wst_q;
  ch_state_t   rst_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [17:0] enable_q;
  logic [15:0] regv [`NUM_REGS];
  logic        do_write;
  logic [3:0]  wsel;
  logic [3:0]  rsel;

  // address and data may arrive in either order; each is held once taken
  assign s_axi_awready = (wst_q == CH_IDLE) && !aw_have_q;
  assign s_axi_wready  = (wst_q == CH_IDLE) && !w_have_q;
  assign do_write      = (wst_q == CH_IDLE) &&
                         (aw_have_q || s_axi_awvalid) &&
                         (w_have_q || s_axi_wvalid);
  assign wsel = decode(aw_have_q ? wreq_q.addr : s_axi_awaddr);

  // capture of write address and data halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreq_q    <= '0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wreq_q.addr <= s_axi_awaddr;
        aw_have_q   <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
        w_have_q    <= 1'b1;
      end
    end
  end

  logic [31:0] wdata_eff;
  logic [3:0]  wstrb_eff;
  assign wdata_eff = w_have_q ? wreq_q.data : s_axi_wdata;
  assign wstrb_eff = w_have_q ? wreq_q.strb : s_axi_wstrb;

  // write response; unmapped offsets answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q   <= CH_IDLE;
      bresp_q <= `RESP_OKAY;
    end else begin
      case (wst_q)
        CH_IDLE: begin
          if (do_write) begin
            wst_q   <= CH_RESP;
            bresp_q <= (wsel == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
          end
        end
        CH_RESP: begin
          if (s_axi_bready) begin
            wst_q <= CH_IDLE;
          end
        end
        default: wst_q <= CH_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = (wst_q == CH_RESP);
  assign s_axi_bresp  = bresp_q;

  // the five level registers with their own implemented-bit masks
  for (genvar g = 0; g < `NUM_REGS; g++) begin : g_reg
    localparam logic [15:0] M = (g == 2) ? `MASK_REG3 : // see RL9
                                (g == 3) ? `MASK_REG4 : // see RL10
                                `MASK_FULL;
    level_reg #(.MASK(M)) u_reg (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (do_write && (wsel == 4'(g))),
      .wr_strb (wstrb_eff[1:0]),
      .wr_data (wdata_eff[15:0]),
      .value   (regv[g])
    );
  end

  // source enable gate register; all sources blocked at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= '0;
    end else if (do_write && (wsel == 4'h5)) begin
      if (wstrb_eff[0]) enable_q[7:0]   <= wdata_eff[7:0];
      if (wstrb_eff[1]) enable_q[15:8]  <= wdata_eff[15:8];
      if (wstrb_eff[2]) enable_q[17:16] <= wdata_eff[17:16];
    end
  end

  // read channel: data registered, one item in flight
  assign s_axi_arready = (rst_q == CH_IDLE);
  assign rsel          = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q   <= CH_IDLE;
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end else begin
      case (rst_q)
        CH_IDLE: begin
          if (s_axi_arvalid) begin
            rst_q   <= CH_RESP;
            rresp_q <= (rsel == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
            if (rsel < 4'(`NUM_REGS)) begin
              rdata_q <= {16'h0000, regv[rsel[2:0]]}; // see RL5
            end else if (rsel == 4'h5) begin
              rdata_q <= {14'h0000, enable_q};
            end else begin
              rdata_q <= '0;
            end
          end
        end
        CH_RESP: begin
          if (s_axi_rready) begin
            rst_q <= CH_IDLE;
          end
        end
        default: rst_q <= CH_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid = (rst_q == CH_RESP);
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // levels straight from the flops, so a write acts next cycle
  assign timer_2_level         = fld(regv[0], `FLD_HI_LSB); // see RL7
  assign out_compare_2_level   = fld(regv[0], `FLD_MH_LSB); // see RL13
  assign in_capture_2_level    = fld(regv[0], `FLD_ML_LSB);
  assign dma_ch0_done_level    = fld(regv[0], `FLD_LO_LSB);
  assign uart_1_receive_level  = fld(regv[1], `FLD_HI_LSB); // see RL8
  assign spi_1_event_level     = fld(regv[1], `FLD_MH_LSB);
  assign spi_1_error_level     = fld(regv[1], `FLD_ML_LSB);
  assign timer_3_level         = fld(regv[1], `FLD_LO_LSB);
  assign dma_ch1_done_level    = fld(regv[2], `FLD_MH_LSB); // see RL9
  assign adc_1_done_level      = fld(regv[2], `FLD_ML_LSB);
  assign uart_1_transmit_level = fld(regv[2], `FLD_LO_LSB);
  assign change_notify_level   = fld(regv[3], `FLD_HI_LSB); // see RL10
  assign i2c_1_master_level    = fld(regv[3], `FLD_ML_LSB);
  assign i2c_1_slave_level     = fld(regv[3], `FLD_LO_LSB);
  assign in_capture_8_level    = fld(regv[4], `FLD_HI_LSB); // see RL11
  assign in_capture_7_level    = fld(regv[4], `FLD_MH_LSB);
  assign adc_2_done_level      = fld(regv[4], `FLD_ML_LSB);
  assign ext_irq_1_level       = fld(regv[4], `FLD_LO_LSB);

  // level codes pass unchanged: 1 lowest, 7 highest, linear between
  logic [`NUM_SRC*`LEVEL_W-1:0] all_levels;
  assign all_levels = {ext_irq_1_level, adc_2_done_level,
    in_capture_7_level, in_capture_8_level, i2c_1_slave_level,
    i2c_1_master_level, change_notify_level, uart_1_transmit_level,
    adc_1_done_level, dma_ch1_done_level, timer_3_level,
    spi_1_error_level, spi_1_event_level, uart_1_receive_level,
    dma_ch0_done_level, in_capture_2_level, out_compare_2_level,
    timer_2_level}; // see RL1, see RL3

  src_gate u_gate (
    .levels  (all_levels),
    .enables (enable_q),
    .pending (src_pending),
    .request (src_request)
  );

  // assertions
  AST_RESET_LEVEL: assert property (@(posedge aclk) // see RL4
    $rose(aresetn) |-> timer_2_level == `LEVEL_RESET &&
      ext_irq_1_level == `LEVEL_RESET)
    else $error("reset level not four");
  AST_OFF_NO_REQ: assert property ( // see RL2
    @(posedge aclk) disable iff (!aresetn)
    timer_2_level == `LEVEL_OFF |-> !src_request[0])
    else $error("disabled source requested");
  AST_EN_GATE: assert property ( // see RL12
    @(posedge aclk) disable iff (!aresetn)
    !enable_q[17] |-> !src_request[17])
    else $error("request with enable clear");
  AST_REQ_PASS: assert property ( // see RL3
    @(posedge aclk) disable iff (!aresetn)
    src_pending[0] && enable_q[0] && timer_2_level != `LEVEL_OFF
      |-> src_request[0])
    else $error("enabled request lost");
  AST_WRITE_NEXT: assert property ( // see RL13
    @(posedge aclk) disable iff (!aresetn)
    do_write && wsel == 4'h0 && wstrb_eff[1]
      |=> timer_2_level == $past(wdata_eff[14:12]))
    else $error("write not seen next cycle");
  AST_REG3_ZERO: assert property ( // see RL9
    @(posedge aclk) disable iff (!aresetn)
    regv[2][15:11] == 5'h00)
    else $error("register 3 upper bits set");
  AST_REG4_ZERO: assert property ( // see RL10
    @(posedge aclk) disable iff (!aresetn)
    regv[3][11:7] == 5'h00)
    else $error("register 4 middle bits set");
  AST_READBACK: assert property ( // see RL6
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && rsel == 4'h4
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(regv[4])})
    else $error("readback mismatch");
  AST_FIELD_MAP: assert property ( // see RL8
    @(posedge aclk) disable iff (!aresetn)
    uart_1_receive_level == regv[1][14:12] &&
      spi_1_error_level == regv[1][6:4])
    else $error("field map wrong");
  // a write stays acknowledged until software takes the response
  AST_BVALID_HOLD: assert property ( // see RL6
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  COV_WRITE: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  COV_SLVERR: cover property (@(posedge aclk)
    s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  COV_MAXLVL: cover property (@(posedge aclk)
    timer_2_level == `LEVEL_MAX && src_request[0]);
endmodule
`default_nettype wire

// file: sim/test_irq_priority_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_defines.svh"

module test_irq_priority_bank;
  import prio_bank_pkg::*;

  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [17:0] src_pending, src_request;
  level_t      lvl [18];
  int          errors, total_checks;
  logic [2:0]  code_q [18];
  logic [15:0] vals [5];
  // implemented bits per register; unimplemented ones read zero
  logic [15:0] mask [5] = '{16'h7777, 16'h7777, 16'h0777, 16'h7077, 16'h7777};
  // source index of each field, hi to lo; -1 where the field is unimplemented
  int          fmap [5][4] = '{'{0, 1, 2, 3}, '{4, 5, 6, 7}, '{-1, 8, 9, 10},
                               '{11, -1, 12, 13}, '{14, 15, 16, 17}};

  irq_priority_bank uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_pending(src_pending),
    .timer_2_level(lvl[0]), .out_compare_2_level(lvl[1]),
    .in_capture_2_level(lvl[2]), .dma_ch0_done_level(lvl[3]),
    .uart_1_receive_level(lvl[4]), .spi_1_event_level(lvl[5]),
    .spi_1_error_level(lvl[6]), .timer_3_level(lvl[7]),
    .dma_ch1_done_level(lvl[8]), .adc_1_done_level(lvl[9]),
    .uart_1_transmit_level(lvl[10]), .change_notify_level(lvl[11]),
    .i2c_1_master_level(lvl[12]), .i2c_1_slave_level(lvl[13]),
    .in_capture_8_level(lvl[14]), .in_capture_7_level(lvl[15]),
    .adc_2_done_level(lvl[16]), .ext_irq_1_level(lvl[17]),
    .src_request(src_request)
  );

  // free-running 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  // one write; bready rises an edge late so the response is seen waiting
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w) && n < 100);
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) chk("write handshake", 32'h1, 32'h0);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 100);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) chk("read handshake", 32'h1, 32'h0);
  endtask

  // reset, used at start and again at the end of the run, then default contents
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axi_read(12'(4 * i), d, r);
      chk("reset value", {16'h0, 16'h4444 & mask[i]}, d);
      chk("reset rresp", `RESP_OKAY, r);
      vals[i] = 16'h4444 & mask[i];
    end
    axi_read(`OFF_SRC_ENABLE, d, r);
    chk("enable reset", 32'h0, d);
    for (int i = 0; i < 18; i++) begin
      chk("level reset", 32'h4, lvl[i]);
      code_q[i] = 3'h4;
    end
    chk("request reset", 32'h0, src_request);
    $display("test reset done");
  endtask

  // codes cycling 1-7 then 0 into every field, the top bit of each nibble written as one
  task automatic t_map;
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] v;
    logic [2:0]  c;
    int          s;
    for (int k = 0; k < 5; k++) begin
      v = 16'h8888;
      for (int f = 0; f < 4; f++) begin
        c = 3'((k * 4 + f + 1) % 8);
        v[(3 - f) * 4 +: 3] = c;
        if (fmap[k][f] >= 0) code_q[fmap[k][f]] = c;
      end
      axi_write(12'(4 * k), {16'hffff, v}, 4'h3, r);
      chk("write bresp", `RESP_OKAY, r);
      for (int f = 0; f < 4; f++) begin
        s = fmap[k][f];
        if (s >= 0)
          chk("level map", code_q[s], lvl[s]);
      end
      vals[k] = v & mask[k];
      axi_read(12'(4 * k), d, r);
      chk("readback", {16'h0, vals[k]}, d);
    end
    // upper byte only: the lower fields must keep their codes
    axi_write(`OFF_PRIO_CTRL_2, 32'h0, 4'h2, r);
    axi_read(`OFF_PRIO_CTRL_2, d, r);
    vals[1] = vals[1] & 16'h00ff;
    code_q[4] = 3'h0;
    code_q[5] = 3'h0;
    chk("byte strobe", {16'h0, vals[1]}, d);
    chk("strobe kept", 32'(code_q[6]), lvl[6]);
    chk("strobe cleared", 32'h0, lvl[4]);
    $display("test map done");
  endtask

  // request gating by enable, level and pending, every code on one source
  task automatic t_gate;
    logic [1:0]  r;
    logic [17:0] e;
    axi_write(`OFF_SRC_ENABLE, 32'h0003ffff, 4'hf, r);
    src_pending <= 18'h2aaaa;
    @(posedge aclk);
    for (int i = 0; i < 18; i++) e[i] = (i % 2 == 1) && (code_q[i] != 3'h0);
    chk("request pending", {14'h0, e}, src_request);
    axi_write(`OFF_SRC_ENABLE, 32'h00015555, 4'hf, r);
    src_pending <= 18'h3ffff;
    @(posedge aclk);
    for (int i = 0; i < 18; i++) e[i] = (i % 2 == 0) && (code_q[i] != 3'h0);
    chk("request enable", {14'h0, e}, src_request);
    for (int c = 0; c < 8; c++) begin
      axi_write(`OFF_PRIO_CTRL_1, {16'h0, vals[0] & 16'h0fff | 16'(c << 12)},
                4'h3, r);
      chk("code level", 32'(c), lvl[0]);
      chk("code request", 32'(c != 0), src_request[0]);
    end
    axi_write(`OFF_SRC_ENABLE, 32'h0, 4'hf, r);
    @(posedge aclk);
    chk("request off", 32'h0, src_request);
    $display("test gate done");
  endtask

  // unmapped offset is refused and leaves the bank untouched
  task automatic t_bad;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(12'h020, 32'hffffffff, 4'hf, r);
    chk("unmapped bresp", `RESP_SLVERR, r);
    axi_read(12'h020, d, r);
    chk("unmapped rresp", `RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, d);
    axi_read(`OFF_PRIO_CTRL_5, d, r);
    chk("bank intact", {16'h0, vals[4]}, d);
    $display("test unmapped done");
  endtask

  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 12'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    src_pending = 18'h3ffff;
    t_reset();
    t_map();
    t_gate();
    t_bad();
    t_reset();
    summarize();
  end

  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize();
  end
endmodule

`default_nettype wire
